// ### common/ssft_pkg.sv
// Register map, field layout and encodings of the framing block
`default_nettype none
package ssft_pkg;
   localparam int SSFT_AW = 8;
   localparam logic [7:0] O_CTRL = 8'h00;
   localparam logic [7:0] O_DIV = 8'h04;
   localparam logic [7:0] O_RXF = 8'h08;
   localparam logic [7:0] O_TCK = 8'h0C;
   localparam logic [7:0] O_TXF = 8'h10;
   localparam logic [7:0] O_RXD = 8'h14;
   localparam logic [7:0] O_TXD = 8'h18;
   localparam logic [7:0] O_RXS = 8'h1C;
   localparam logic [7:0] O_TXS = 8'h20;
   localparam logic [7:0] O_STAT = 8'h24;
   localparam logic [7:0] O_RXP = 8'h28;
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   // Writable bits; the rest read zero
   localparam logic [31:0] M_CTRL = 32'h0000_0003;
   localparam logic [31:0] M_DIV = 32'h0000_0FFF;
   localparam logic [31:0] M_RXF = 32'hF17F_0FBF;
   localparam logic [31:0] M_TXF = 32'hF1FF_0FBF;
   localparam logic [31:0] M_TCK = 32'hFFFF_0FFF;
   localparam logic [31:0] M_RXP = 32'h0000_00FF;
   localparam logic [31:0] M_TXS = 32'h0000_FFFF;
   localparam int F_RXEN = 0;
   localparam int F_TXEN = 1;
   localparam int F_DLEN = 0;
   localparam int F_LOOP = 5;
   localparam int F_DDEF = 5;
   localparam int F_BIT_ORDER_SELECT = 7;
   localparam int F_WPF = 8;
   localparam int F_FSL = 16;
   localparam int F_SYNC_OUTPUT_SHAPE = 20;
   localparam int F_SYNC_DATA_OUTPUT_ENABLE = 23;
   localparam int F_EDGE = 24;
   localparam int F_FSH = 28;
   localparam int F_CKS = 0;
   localparam int F_CKO = 2;
   localparam int F_CKI = 5;
   localparam int F_CKG = 6;
   localparam int F_START = 8;
   localparam int F_DLY = 16;
   localparam int F_PER = 24;
   localparam int S_TXRDY = 0;
   localparam int S_TXEMP = 1;
   localparam int S_RXRDY = 4;
   localparam int S_TX_SYNC_EVENT = 10;
   localparam int S_RX_SYNC_EVENT = 11;
   localparam int S_TXEN = 16;
   localparam int S_RXEN = 17;
   localparam int S_TXSZ = 24;
   localparam int S_RXSZ = 26;
   localparam logic [1:0] CKS_DIV = 2'h0;
   localparam logic [1:0] CKS_RX = 2'h1;
   localparam logic [1:0] CKS_PIN = 2'h2;
   localparam logic [2:0] CKO_CONT = 3'h1;
   localparam logic [2:0] CKO_XFER = 3'h2;
   localparam logic [1:0] CKG_LOW = 2'h1;
   localparam logic [1:0] CKG_HIGH = 2'h2;
   localparam logic [3:0] ST_WRITE = 4'h0;
   localparam logic [3:0] ST_RX = 4'h1;
   localparam logic [3:0] ST_LOW = 4'h2;
   localparam logic [3:0] ST_HIGH = 4'h3;
   localparam logic [3:0] ST_FALL = 4'h4;
   localparam logic [3:0] ST_RISE = 4'h5;
   localparam logic [3:0] ST_CHG = 4'h6;
   localparam logic [3:0] ST_EDGE = 4'h7;
   localparam logic [2:0] FS_NEG = 3'h1;
   localparam logic [2:0] FS_POS = 3'h2;
   localparam logic [2:0] FS_LOW = 3'h3;
   localparam logic [2:0] FS_HIGH = 3'h4;
   localparam logic [2:0] FS_TOG = 3'h5;
   localparam logic [4:0] BYTE_MAX = 5'h07;
   localparam logic [4:0] HALF_MAX = 5'h0F;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_DELAY = 4'b0010,
      TX_WAIT = 4'b0100,
      TX_DATA = 4'b1000
   } ssft_tx_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_SYNC = 3'b010,
      RX_DATA = 3'b100
   } ssft_rx_t;
endpackage
`default_nettype wire

// ### hw/ssft_framer.sv
// Frame-sync generator: period divider, pulse, output shape, edge event
`timescale 1ns/10ps
`default_nettype none
module ssft_framer
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic busy_i,
   input wire logic [7:0] period_i,
   input wire logic [3:0] len_low_i,
   input wire logic [3:0] len_high_i,
   input wire logic [2:0] shape_i,
   input wire logic edge_sel_i,
   input wire logic fs_in_i,
   output logic fs_o,
   output logic fs_oe_o,
   output logic line_o,
   output logic period_evt_o,
   output logic sync_evt_o,
   output logic pulse_o,
   output logic [8:0] pulse_idx_o
);
   import ssft_pkg::*;
   logic [8:0] per_cnt_r;
   logic [8:0] per_last;
   logic [8:0] pulse_last;
   logic trig;
   logic tog_r;
   logic prev_r;
   logic fs_nxt;

   assign per_last = {period_i, 1'b1};
   assign pulse_last = {1'b0, len_high_i, len_low_i};
   assign period_evt_o = (period_i != 8'h00) & tick_i
      & (per_cnt_r == per_last);
   assign trig = start_i | period_evt_o;
   assign fs_oe_o = (shape_i >= FS_NEG) & (shape_i <= FS_TOG);
   assign line_o = fs_oe_o ? fs_o : fs_in_i;
   assign sync_evt_o = edge_sel_i ? (prev_r & ~line_o)
      : (~prev_r & line_o);

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || period_i == 8'h00)
         per_cnt_r <= 9'h000;
      else if (tick_i)
         per_cnt_r <= (per_cnt_r == per_last) ? 9'h000
            : per_cnt_r + 9'h001;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         pulse_o <= 1'b0;
         pulse_idx_o <= 9'h000;
      end
      else if (trig)
      begin
         pulse_o <= 1'b1;
         pulse_idx_o <= 9'h000;
      end
      else if (pulse_o && tick_i)
      begin
         if (pulse_idx_o == pulse_last)
            pulse_o <= 1'b0;
         else
            pulse_idx_o <= pulse_idx_o + 9'h001;
      end
   end

   always_comb
   begin
      case (shape_i)
         FS_NEG: fs_nxt = ~pulse_o;
         FS_POS: fs_nxt = pulse_o;
         FS_LOW: fs_nxt = ~busy_i;
         FS_HIGH: fs_nxt = busy_i;
         FS_TOG: fs_nxt = tog_r;
         default: fs_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      // Line history runs through reset, so no false edge after it
      prev_r <= line_o;
      if (sys_rst_i)
      begin
         fs_o <= 1'b0;
         tog_r <= 1'b0;
      end
      else
      begin
         fs_o <= fs_nxt;
         tog_r <= tog_r ^ trig;
      end
   end
endmodule
`default_nettype wire

// ### hw/ssft_top.sv
// Serial frame timing block with APB registers
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Nonzero rx period field: event every 2*(field+1) rx clocks; zero none
// - Word length is field plus one bits; zero is forbidden
// - DMA size: byte up to 7, half-word 8 to 15, else word
// - Loopback feeds rx data, sync and clock from the tx side
// - Rx bit order 1: first bit to MSB; 0: to LSB
// - Tx bit order 1: MSB shifted first; 0: LSB first
// - Each start moves words-per-frame plus one words per direction
// - Rx sync length sets bits sampled into rx sync data
// - Sync pulse length is low + 16*high + 1 clock periods
// - Rx sync shape: none, neg, pos, low, high, toggle; 6-7 reserved
// - Tx sync shape uses the same encoding on the tx sync pin
// - Rx edge select: 0 rising, 1 falling raises rx sync event
// - Tx clock source: divided clock, rx clock pin, tx clock pin
// - Tx clock pin: input-only, continuous, or only during transfers
// - Inversion swaps shift and sample edges; output clock untouched
// - Tx clock gating: continuous, while sync low, while sync high
// - Tx start: on write, with receiver, or sync level/edge
// - Nonzero start delay inserts that many clocks before first bit
// - Nonzero tx period field: event every 2*(field+1) tx clocks
// - Idle level drives the tx data pin outside transmission
// - Tx sync length bits of sync data shifted out during sync
// - Sync data disabled: idle level on data pin during sync
// - Tx edge select: 0 rising, 1 falling raises tx sync event
module ssft_top
#(
   parameter int ADDR_W = ssft_pkg::SSFT_AW
)
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic tx_clock_pin_i,
   output logic tx_clock_pin_o,
   output logic tx_clock_pin_oe_o,
   input wire logic rx_clock_pin_i,
   input wire logic tx_frame_sync_pin_i,
   output logic tx_frame_sync_pin_o,
   output logic tx_frame_sync_pin_oe_o,
   input wire logic rx_frame_sync_pin_i,
   output logic rx_frame_sync_pin_o,
   output logic rx_frame_sync_pin_oe_o,
   output logic tx_data_pin_o,
   input wire logic rx_data_pin_i,
   output logic [1:0] tx_dma_size_o,
   output logic [1:0] rx_dma_size_o
);
   import ssft_pkg::*;

   if (ADDR_W < 8)
   begin : g_bad_aw
      $error("ADDR_W must be at least 8");
   end

   logic [31:0] ctrl_r, div_r, rxf_r, tck_r, txf_r, rxp_r, tsh_r;
   logic [31:0] tx_hold_r, rx_hold_r, rx_word_r, rx_word_nxt;
   logic [15:0] rx_sync_r;
   logic [31:0] rd_val, stat_w;
   logic [7:0] ofs;
   logic hit, acc, wr, rd, rx_rdy_cap_r;
   logic [11:0] div_cnt_r;
   logic div_clk_r, tx_clk, tx_prev_r, rx_clk, rx_prev_r;
   logic gate_on, sh_tk, smp_tk, rx_tk, tf_smp_r;
   logic tx_en, rx_en, tx_busy, rx_busy, trig, tx_go, rx_go, tx_load;
   logic hold_full_r, rx_rdy_r, tx_sync_event_r, rx_sync_event_r, td_nxt, rd_bit;
   logic tf_line, rf_line, tx_pulse, tx_per_evt, rx_per_evt;
   logic tx_sync_evt, rx_sync_evt, rx_pulse;
   logic [8:0] tx_pidx;
   logic [4:0] tx_idx_r, rx_idx_r, tx_pos, rx_pos;
   logic [3:0] tx_wcnt_r, rx_wcnt_r;
   logic [7:0] dly_r;
   ssft_tx_t tx_st_r;
   ssft_rx_t rx_st_r;

   logic [4:0] rx_wl, tx_wl;
   logic [3:0] rx_wpf, tx_wpf, rx_fsl, tx_fsl, rx_fsh, tx_fsh, tx_ss;
   logic [2:0] rx_sh, tx_sh, tx_cko;
   logic [1:0] tx_cks, tx_ckg;
   logic [7:0] tx_dly, tx_per, rx_per;
   logic rx_loop, rx_bit_order_select, tx_bit_order_select, tx_idl, tx_sync_data_output_enable, tx_cki;

   assign rx_wl = rxf_r[F_DLEN +: 5];
   assign tx_wl = txf_r[F_DLEN +: 5];
   assign rx_loop = rxf_r[F_LOOP];
   assign tx_idl = txf_r[F_DDEF];
   assign rx_bit_order_select = rxf_r[F_BIT_ORDER_SELECT];
   assign tx_bit_order_select = txf_r[F_BIT_ORDER_SELECT];
   assign rx_wpf = rxf_r[F_WPF +: 4];
   assign tx_wpf = txf_r[F_WPF +: 4];
   assign rx_fsl = rxf_r[F_FSL +: 4];
   assign tx_fsl = txf_r[F_FSL +: 4];
   assign rx_sh = rxf_r[F_SYNC_OUTPUT_SHAPE +: 3];
   assign tx_sh = txf_r[F_SYNC_OUTPUT_SHAPE +: 3];
   assign tx_sync_data_output_enable = txf_r[F_SYNC_DATA_OUTPUT_ENABLE];
   assign rx_fsh = rxf_r[F_FSH +: 4];
   assign tx_fsh = txf_r[F_FSH +: 4];
   assign tx_cks = tck_r[F_CKS +: 2];
   assign tx_cko = tck_r[F_CKO +: 3];
   assign tx_cki = tck_r[F_CKI];
   assign tx_ckg = tck_r[F_CKG +: 2];
   assign tx_ss = tck_r[F_START +: 4];
   assign tx_dly = tck_r[F_DLY +: 8];
   assign tx_per = tck_r[F_PER +: 8];
   assign rx_per = rxp_r[7:0];
   assign rx_en = ctrl_r[F_RXEN];
   assign tx_en = ctrl_r[F_TXEN];

   function automatic logic [1:0] xsize(input logic [4:0] wl);
      if (wl <= BYTE_MAX)
         xsize = SZ_BYTE;
      else if (wl <= HALF_MAX)
         xsize = SZ_HALF;
      else
         xsize = SZ_WORD;
   endfunction

   assign tx_dma_size_o = xsize(tx_wl);
   assign rx_dma_size_o = xsize(rx_wl);

   // APB slave, zero wait states
   assign ofs = paddr_i[7:0];
   assign acc = psel_i & penable_i;
   assign wr = acc & pwrite_i;
   assign rd = acc & ~pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = acc & ~hit;

   always_comb
   begin
      stat_w = 32'h0000_0000;
      stat_w[S_TXRDY] = ~hold_full_r;
      stat_w[S_TXEMP] = ~hold_full_r & ~tx_busy;
      stat_w[S_RXRDY] = rx_rdy_r;
      stat_w[S_TX_SYNC_EVENT] = tx_sync_event_r;
      stat_w[S_RX_SYNC_EVENT] = rx_sync_event_r;
      stat_w[S_TXEN] = tx_en;
      stat_w[S_RXEN] = rx_en;
      stat_w[S_TXSZ +: 2] = tx_dma_size_o;
      stat_w[S_RXSZ +: 2] = rx_dma_size_o;
   end

   always_comb
   begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      case (ofs)
         O_CTRL: rd_val = ctrl_r;
         O_DIV: rd_val = div_r;
         O_RXF: rd_val = rxf_r;
         O_TCK: rd_val = tck_r;
         O_TXF: rd_val = txf_r;
         O_RXD: rd_val = rx_hold_r;
         O_TXD: rd_val = 32'h0000_0000;
         O_RXS: rd_val = {16'h0000, rx_sync_r};
         O_TXS: rd_val = tsh_r;
         O_STAT: rd_val = stat_w;
         O_RXP: rd_val = rxp_r;
         default: hit = 1'b0;
      endcase
      if ((paddr_i >> 8) != '0)
         hit = 1'b0;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         prdata_o <= 32'h0000_0000;
         rx_rdy_cap_r <= 1'b0;
      end
      else if (psel_i && !penable_i)
      begin
         prdata_o <= rd_val;
         rx_rdy_cap_r <= rx_rdy_r;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_r <= RST_VAL;
         div_r <= RST_VAL;
         rxf_r <= RST_VAL;
         tck_r <= RST_VAL;
         txf_r <= RST_VAL;
         rxp_r <= RST_VAL;
         tsh_r <= RST_VAL;
      end
      else if (wr)
      begin
         case (ofs)
            O_CTRL: ctrl_r <= pwdata_i & M_CTRL;
            O_DIV: div_r <= pwdata_i & M_DIV;
            O_RXF: rxf_r <= pwdata_i & M_RXF;
            O_TCK: tck_r <= pwdata_i & M_TCK;
            O_TXF: txf_r <= pwdata_i & M_TXF;
            O_RXP: rxp_r <= pwdata_i & M_RXP;
            O_TXS: tsh_r <= pwdata_i & M_TXS;
            default: ;
         endcase
      end
   end

   // Sticky flags; a set wins over a read clear
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_sync_event_r <= 1'b0;
         rx_sync_event_r <= 1'b0;
         rx_rdy_r <= 1'b0;
      end
      else
      begin
         tx_sync_event_r <= tx_sync_evt | (tx_sync_event_r
            & ~(rd && ofs == O_STAT && prdata_o[S_TX_SYNC_EVENT]));
         rx_sync_event_r <= rx_sync_evt | (rx_sync_event_r
            & ~(rd && ofs == O_STAT && prdata_o[S_RX_SYNC_EVENT]));
         rx_rdy_r <= (rx_tk && rx_st_r == RX_DATA && rx_idx_r == rx_wl)
            | (rx_rdy_r & ~(rd && ofs == O_RXD && rx_rdy_cap_r));
      end
   end

   // Divided clock, period twice the divider in system clocks
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i || div_r[11:0] == 12'h000)
      begin
         div_cnt_r <= 12'h000;
         div_clk_r <= 1'b0;
      end
      else if (div_cnt_r == div_r[11:0] - 12'h001)
      begin
         div_cnt_r <= 12'h000;
         div_clk_r <= ~div_clk_r;
      end
      else
         div_cnt_r <= div_cnt_r + 12'h001;
   end

   always_comb
   begin
      case (tx_cks)
         CKS_DIV: tx_clk = div_clk_r;
         CKS_RX: tx_clk = rx_clock_pin_i;
         CKS_PIN: tx_clk = tx_clock_pin_i;
         default: tx_clk = 1'b0;
      endcase
   end

   assign rx_clk = rx_loop ? tx_clk : rx_clock_pin_i;
   assign gate_on = (tx_ckg == CKG_LOW) ? ~tf_line
      : (tx_ckg == CKG_HIGH) ? tf_line : (tx_ckg == 2'h0);
   assign sh_tk = gate_on & (tx_cki ? (tx_clk & ~tx_prev_r)
      : (~tx_clk & tx_prev_r));
   assign smp_tk = gate_on & (tx_cki ? (~tx_clk & tx_prev_r)
      : (tx_clk & ~tx_prev_r));
   assign rx_tk = rx_clk & ~rx_prev_r;

   // Edge history runs through reset, so no false edge after it
   always_ff @(posedge sys_clk_i)
   begin
      tx_prev_r <= tx_clk;
      rx_prev_r <= rx_clk;
      if (sys_rst_i || smp_tk)
         tf_smp_r <= tf_line;
   end

   always_comb
   begin
      case (tx_ss)
         ST_WRITE: trig = hold_full_r;
         ST_RX: trig = rx_go;
         ST_LOW: trig = smp_tk & ~tf_line;
         ST_HIGH: trig = smp_tk & tf_line;
         ST_FALL: trig = smp_tk & tf_smp_r & ~tf_line;
         ST_RISE: trig = smp_tk & ~tf_smp_r & tf_line;
         ST_CHG, ST_EDGE: trig = smp_tk & (tf_smp_r ^ tf_line);
         default: trig = 1'b0;
      endcase
   end

   assign tx_busy = tx_st_r != TX_IDLE;
   assign tx_go = tx_en & ~tx_busy & trig;
   assign rx_busy = rx_st_r != RX_IDLE;
   assign rx_go = rx_en & ~rx_busy & (rx_sync_evt | rx_per_evt);
   assign tx_load = sh_tk & hold_full_r & ((tx_st_r == TX_WAIT)
      | (tx_st_r == TX_DATA && tx_idx_r == tx_wl && tx_wcnt_r != tx_wpf));
   assign tx_pos = tx_bit_order_select ? tx_wl - tx_idx_r : tx_idx_r;

   // Holding register; a write wins over a load
   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         hold_full_r <= 1'b0;
         tx_hold_r <= 32'h0000_0000;
      end
      else if (wr && ofs == O_TXD)
      begin
         hold_full_r <= 1'b1;
         tx_hold_r <= pwdata_i;
      end
      else if (tx_load)
         hold_full_r <= 1'b0;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_st_r <= TX_IDLE;
         dly_r <= 8'h00;
         tx_idx_r <= 5'h00;
         tx_wcnt_r <= 4'h0;
      end
      else
      begin
         if (tx_load)
            tx_idx_r <= 5'h00;
         case (tx_st_r)
            TX_IDLE:
               if (tx_go)
               begin
                  tx_st_r <= TX_DELAY;
                  dly_r <= tx_dly;
                  tx_wcnt_r <= 4'h0;
               end
            TX_DELAY:
               if (dly_r == 8'h00)
                  tx_st_r <= TX_WAIT;
               else if (sh_tk)
                  dly_r <= dly_r - 8'h01;
            TX_WAIT:
               if (tx_load)
                  tx_st_r <= TX_DATA;
            TX_DATA:
               if (sh_tk && tx_idx_r == tx_wl)
               begin
                  if (tx_wcnt_r == tx_wpf)
                     tx_st_r <= TX_IDLE;
                  else
                  begin
                     tx_wcnt_r <= tx_wcnt_r + 4'h1;
                     if (!tx_load)
                        tx_st_r <= TX_WAIT;
                  end
               end
               else if (sh_tk)
                  tx_idx_r <= tx_idx_r + 5'h01;
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end

   logic [31:0] tx_word_r;

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
         tx_word_r <= 32'h0000_0000;
      else if (tx_load)
         tx_word_r <= tx_hold_r;
   end

   always_comb
   begin
      if (tx_st_r == TX_DATA)
         td_nxt = tx_word_r[tx_pos];
      else if (tx_pulse && tx_sync_data_output_enable && tx_pidx < {5'h00, tx_fsl})
         td_nxt = tsh_r[tx_pidx[3:0]];
      else
         td_nxt = tx_idl;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_data_pin_o <= 1'b0;
         tx_clock_pin_o <= 1'b0;
      end
      else
      begin
         tx_data_pin_o <= td_nxt;
         tx_clock_pin_o <= tx_clk & ((tx_cko == CKO_CONT)
            | (tx_cko == CKO_XFER && tx_st_r == TX_DATA));
      end
   end

   assign tx_clock_pin_oe_o = (tx_cko == CKO_CONT) | (tx_cko == CKO_XFER);

   assign rd_bit = rx_loop ? tx_data_pin_o : rx_data_pin_i;
   assign rx_pos = rx_bit_order_select ? rx_wl - rx_idx_r : rx_idx_r;

   always_comb
   begin
      rx_word_nxt = rx_word_r;
      rx_word_nxt[rx_pos] = rd_bit;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         rx_st_r <= RX_IDLE;
         rx_idx_r <= 5'h00;
         rx_wcnt_r <= 4'h0;
         rx_word_r <= 32'h0000_0000;
         rx_hold_r <= 32'h0000_0000;
         rx_sync_r <= 16'h0000;
      end
      else
      begin
         case (rx_st_r)
            RX_IDLE:
               if (rx_go)
               begin
                  rx_st_r <= (rx_fsl != 4'h0) ? RX_SYNC : RX_DATA;
                  rx_idx_r <= 5'h00;
                  rx_wcnt_r <= 4'h0;
                  rx_word_r <= 32'h0000_0000;
               end
            RX_SYNC:
               if (rx_tk)
               begin
                  rx_sync_r[rx_idx_r[3:0]] <= rd_bit;
                  if (rx_idx_r[3:0] == rx_fsl - 4'h1)
                  begin
                     rx_st_r <= RX_DATA;
                     rx_idx_r <= 5'h00;
                  end
                  else
                     rx_idx_r <= rx_idx_r + 5'h01;
               end
            RX_DATA:
               if (rx_tk && rx_idx_r == rx_wl)
               begin
                  rx_hold_r <= rx_word_nxt;
                  rx_word_r <= 32'h0000_0000;
                  rx_idx_r <= 5'h00;
                  rx_wcnt_r <= rx_wcnt_r + 4'h1;
                  if (rx_wcnt_r == rx_wpf || !rx_en)
                     rx_st_r <= RX_IDLE;
               end
               else if (rx_tk)
               begin
                  rx_word_r <= rx_word_nxt;
                  rx_idx_r <= rx_idx_r + 5'h01;
               end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   ssft_framer u_tx_fs
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(sh_tk),
      .start_i(tx_go),
      .busy_i(tx_st_r == TX_DATA),
      .period_i(tx_per),
      .len_low_i(tx_fsl),
      .len_high_i(tx_fsh),
      .shape_i(tx_sh),
      .edge_sel_i(txf_r[F_EDGE]),
      .fs_in_i(tx_frame_sync_pin_i),
      .fs_o(tx_frame_sync_pin_o),
      .fs_oe_o(tx_frame_sync_pin_oe_o),
      .line_o(tf_line),
      .period_evt_o(tx_per_evt),
      .sync_evt_o(tx_sync_evt),
      .pulse_o(tx_pulse),
      .pulse_idx_o(tx_pidx)
   );

   assign rf_line = rx_loop ? tf_line : rx_frame_sync_pin_i;

   ssft_framer u_rx_fs
   (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(rx_tk),
      .start_i(rx_go),
      .busy_i(rx_busy),
      .period_i(rx_per),
      .len_low_i(rx_fsl),
      .len_high_i(rx_fsh),
      .shape_i(rx_sh),
      .edge_sel_i(rxf_r[F_EDGE]),
      .fs_in_i(rf_line),
      .fs_o(rx_frame_sync_pin_o),
      .fs_oe_o(rx_frame_sync_pin_oe_o),
      .line_o(),
      .period_evt_o(rx_per_evt),
      .sync_evt_o(rx_sync_evt),
      .pulse_o(rx_pulse),
      .pulse_idx_o()
   );

   logic unused_ok;
   assign unused_ok = rx_pulse | tx_per_evt;
endmodule
`default_nettype wire

// ### testbench/ssft_asserts.sv
// Port checker for the frame timing block
`timescale 1ns/10ps
`default_nettype none
module ssft_asserts
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic pslverr_o,
   input wire logic [1:0] tx_dma_size_o,
   input wire logic [1:0] rx_dma_size_o,
   input wire logic tx_clock_pin_oe_o,
   input wire logic tx_frame_sync_pin_oe_o,
   input wire logic rx_frame_sync_pin_oe_o
);
   logic wr;
   assign wr = psel_i && penable_i && pwrite_i;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   a_tsz_legal: assert property (tx_dma_size_o != 2'h3)
      else $error("bad tx size");
   a_rsz_legal: assert property (rx_dma_size_o != 2'h3)
      else $error("bad rx size");
   a_tsz_hold: assert property ($changed(tx_dma_size_o) |-> $past(wr))
      else $error("tx size moved");
   a_rsz_hold: assert property ($changed(rx_dma_size_o) |-> $past(wr))
      else $error("rx size moved");
   a_tk_oe: assert property ($changed(tx_clock_pin_oe_o) |-> $past(wr))
      else $error("tk enable moved");
   a_tf_oe: assert property ($changed(tx_frame_sync_pin_oe_o) |-> $past(wr))
      else $error("tf enable moved");
   a_rf_oe: assert property ($changed(rx_frame_sync_pin_oe_o) |-> $past(wr))
      else $error("rf enable moved");
   a_err_phase: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("error outside access");
endmodule
bind ssft_top ssft_asserts u_chk (.sys_clk_i, .sys_rst_i, .psel_i,
   .penable_i, .pwrite_i, .pslverr_o, .tx_dma_size_o, .rx_dma_size_o,
   .tx_clock_pin_oe_o, .tx_frame_sync_pin_oe_o, .rx_frame_sync_pin_oe_o);
`default_nettype wire

// ### testbench/ssft_peer.sv
// Codec model: serial clock, sync pattern, capture
`timescale 1ns/10ps
`default_nettype none
module ssft_peer
(
   input wire logic sys_clk_i,
   input wire logic run_i,
   input wire logic sd_i,
   input wire logic fs_i,
   output logic sck_o,
   output logic fs_o,
   output logic sd_o,
   output logic [7:0] cap_o
);
   logic [1:0] div_r = 0;
   initial
   begin
      sck_o = 0;
      fs_o = 0;
      sd_o = 0;
      cap_o = 0;
   end
   // Clock stands still while run_i is low
   always @(posedge sys_clk_i)
   begin
      div_r <= div_r + 2'h1;
      sd_o <= ~sd_o;
      fs_o <= sck_o;
      if (run_i && div_r == 2'h3)
         sck_o <= ~sck_o;
   end
   always @(posedge sck_o)
      if (fs_i)
         cap_o <= {cap_o[6:0], sd_i};
endmodule
`default_nettype wire

// ### testbench/ssft_tb_top.sv
// Testbench for the frame timing block
`timescale 1ns/10ps
`default_nettype none
module ssft_tb_top;
   import ssft_pkg::*;
   logic sys_clk_i = 0, sys_rst_i = 1, psel = 0, pen = 0, pwr = 0, run = 0;
   logic [7:0] pa = 0, cap;
   logic [31:0] pwd = 0, prd, rv;
   logic rdy, err, e, tko, tkoe, tfo, tfoe, rfo, rfoe, td, sck, fs, sd;
   logic [1:0] tsz, rsz;
   logic [7:0] offs [3] = '{O_RXF, O_TCK, O_TXF};
   logic [31:0] msk [3] = '{M_RXF, M_TCK, M_TXF};
   logic [31:0] lens [4] = '{1, 8, 15, 16};
   logic [1:0] szs [4] = '{SZ_BYTE, SZ_HALF, SZ_HALF, SZ_WORD};
   int n_mismatch = 0, check_count = 0;
   wire logic tkw = tkoe ? tko : sck;
   wire logic tfw = tfoe ? tfo : fs;
   wire logic rfw = rfoe ? rfo : fs;
   always #50 sys_clk_i = ~sys_clk_i;
   ssft_top u_dut (.sys_clk_i, .sys_rst_i, .paddr_i(pa), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd),
      .pready_o(rdy), .pslverr_o(err), .tx_clock_pin_i(tkw),
      .tx_clock_pin_o(tko), .tx_clock_pin_oe_o(tkoe), .rx_clock_pin_i(sck),
      .tx_frame_sync_pin_i(tfw), .tx_frame_sync_pin_o(tfo),
      .tx_frame_sync_pin_oe_o(tfoe), .rx_frame_sync_pin_i(rfw),
      .rx_frame_sync_pin_o(rfo), .rx_frame_sync_pin_oe_o(rfoe),
      .tx_data_pin_o(td), .rx_data_pin_i(sd), .tx_dma_size_o(tsz),
      .rx_dma_size_o(rsz));
   ssft_peer u_peer (.sys_clk_i, .run_i(run), .sd_i(td), .fs_i(tfw),
      .sck_o(sck), .fs_o(fs), .sd_o(sd), .cap_o(cap));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge sys_clk_i);
      pen <= 1;
      @(posedge sys_clk_i);
      while (rdy !== 1)
         @(posedge sys_clk_i);
      rv = prd;
      e = err;
      psel <= 0;
      pen <= 0;
      #1;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x)
      begin
         n_mismatch++;
         $display("ERROR %s exp %h got %h", n, x, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #2000000;
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 0;
      foreach (offs[i])
      begin
         apb(0, offs[i], 0);
         chk("reset", RST_VAL, rv);
         apb(1, offs[i], 32'hFFFF_FFFF);
         apb(0, offs[i], 0);
         chk("mask", msk[i], rv);
      end
      apb(0, 8'h2C, 0);
      chk("slverr", 1, e);
      chk("unmapped", 0, rv);
      foreach (lens[i])
      begin
         apb(1, O_TXF, lens[i]);
         apb(1, O_RXF, lens[i]);
         chk("tx size", szs[i], tsz);
         chk("rx size", szs[i], rsz);
      end
      chk("rf oe", 0, rfoe);
      apb(1, O_TCK, 32'(CKS_PIN));
      run <= 1;
      for (int m = 0; m < 2; m++)
      begin
         apb(1, O_TXF, 32'h0040_0027 | (32'(m) << F_BIT_ORDER_SELECT));
         apb(1, O_RXF, 32'h0000_0027 | (32'(m) << F_BIT_ORDER_SELECT));
         apb(1, O_CTRL, 32'h0000_0003);
         chk("td idle", 1, td);
         chk("tk oe", 0, tkoe);
         chk("tk", 0, tko);
         chk("tf oe", 1, tfoe);
         apb(1, O_TXD, 32'h35);
         rv = 0;
         while (rv[S_TXEMP] !== 1)
            apb(0, O_STAT, 0);
         repeat (16) @(posedge sys_clk_i);
         chk("word", m ? 8'h35 : 8'hAC, cap);
         apb(0, O_RXD, 0);
         chk("rx word", 8'h35, rv);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
